// File: rtl/acdp_regs.svh
// Register offsets, field positions, reset values and timing for the clock control block
`ifndef ACDP_REGS_SVH
`define ACDP_REGS_SVH

`define ACDP_OFF_CHAN_SEL 15'h0008
`define ACDP_OFF_PWR_A 15'h003f
`define ACDP_OFF_PWR_B 15'h0040
`define ACDP_OFF_CLK_DIV 15'h0108
`define ACDP_OFF_HALF_DLY 15'h0109
`define ACDP_OFF_DLY_CTL 15'h0110
`define ACDP_OFF_SF_DLY 15'h0111
`define ACDP_OFF_FINE_DLY 15'h0112
`define ACDP_OFF_FILL_SEL 15'h0571
`define ACDP_OFF_REF_SRC 15'h18a6
`define ACDP_OFF_CM_EXP 15'h18e3
`define ACDP_OFF_DIODE 15'h18e6

`define ACDP_RST_CHAN_SEL 8'h03

// Field positions
`define ACDP_DIV_RATIO 1:0
`define ACDP_DIV_PHASE 5:4
`define ACDP_DIV_SYNC_EN 7
`define ACDP_HALF_EN 0
`define ACDP_DLY_MODE 2:0
`define ACDP_PWR_REG_MODE 1:0
`define ACDP_PWR_PIN_FUNC 7:6
`define ACDP_FILL_K_BIT 7
`define ACDP_CM_EXP_BIT 6
`define ACDP_REF_EXP_BIT 0

// Field values
`define ACDP_DLY_OFF 3'h0
`define ACDP_DLY_SF_A 3'h2
`define ACDP_DLY_SF_B 3'h6
`define ACDP_FINE_MAX 8'hbf
`define ACDP_SF_MAX 8'h80
`define ACDP_DIODE_1X 8'h01
`define ACDP_DIODE_20X 8'h02

// Serial frame: 16 command bits then 8 data bits
`define ACDP_SPI_CMD_BITS 5'h10
`define ACDP_SPI_FRAME_BITS 5'h18

// Timing
`define ACDP_CLK_MHZ 200
`define ACDP_DPRST_NS 40
`define ACDP_DPRST_CYC (((`ACDP_DPRST_NS * `ACDP_CLK_MHZ) + 999) / 1000)

`endif

// File: rtl/acdp_pkg.sv
// Types shared by the clock control block
package acdp_pkg;
   typedef enum logic [1:0] {
      DIV_BY_1 = 2'h0,
      DIV_BY_2 = 2'h1,
      DIV_BY_4 = 2'h2,
      DIV_RSVD = 2'h3
   } acdp_div_t;

   typedef enum logic [1:0] {
      SPI_IDLE = 2'h0,
      SPI_CMD = 2'h1,
      SPI_DATA = 2'h2,
      SPI_DONE = 2'h3
   } acdp_spi_st_t;

   typedef enum logic [1:0] {
      PWR_ON = 2'h0,
      PWR_STANDBY = 2'h1,
      PWR_DOWN = 2'h2,
      PWR_RSVD = 2'h3
   } acdp_pwr_t;

   typedef enum logic [1:0] {
      PIN_POWER_DOWN_MODE = 2'h0,
      PIN_STBY = 2'h1,
      PIN_OFF = 2'h2,
      PIN_RSVD = 2'h3
   } acdp_pin_fn_t;
endpackage : acdp_pkg

// File: rtl/acdp_clk_div.sv
// Input clock divider producing the sample enable, realigned by SYSREF
`include "acdp_regs.svh"
module acdp_clk_div
(
   input wire logic i_clock, // 200 MHz clock
   input wire logic i_rstn, // Async reset, active low
   input wire acdp_pkg::acdp_div_t i_ratio, // Divide ratio
   input wire logic i_sync, // Valid SYSREF event, one cycle
   input wire logic [1:0] i_phase, // Counter state loaded on SYSREF
   output logic o_div_en // Divided sample enable pulse
);
   import acdp_pkg::*;

   typedef struct packed {
      logic [1:0] cnt;
      logic en;
   } acdp_div_reg_t;

   acdp_div_reg_t st_ff;
   acdp_div_reg_t nxt_st;
   logic [1:0] last;

   always_comb
   begin
      nxt_st = st_ff;
      case (i_ratio)
         DIV_BY_1: last = 2'h0;
         DIV_BY_2: last = 2'h1;
         default: last = 2'h3;
      endcase
      if (i_sync)
         nxt_st.cnt = i_phase & last;
      else if (st_ff.cnt >= last)
         nxt_st.cnt = 2'h0;
      else
         nxt_st.cnt = st_ff.cnt + 2'h1;
      nxt_st.en = (nxt_st.cnt == 2'h0);
   end

   always_ff @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign o_div_en = st_ff.en;

   AST_DIV4_GAP: assert property (@(posedge i_clock) disable iff (!i_rstn)
      o_div_en && i_ratio == DIV_BY_4 && !i_sync |=> !o_div_en)
      else $error("divide by four enable repeated too soon");
   AST_SYNC_PHASE: assert property (@(posedge i_clock) disable iff (!i_rstn)
      i_sync && i_ratio == DIV_BY_4 |=> o_div_en == ($past(i_phase) == 2'h0))
      else $error("divider not loaded with programmed phase on SYSREF");
endmodule : acdp_clk_div

// File: rtl/acdp_spi_slave.sv
// Serial register port: 16-bit command (read flag, 15-bit address), 8 data bits
`include "acdp_regs.svh"
module acdp_spi_slave
(
   input wire logic i_clock, // 200 MHz clock
   input wire logic i_rstn, // Async reset, active low
   input wire logic i_sclk, // Serial clock pin
   input wire logic i_csb_n, // Chip select pin, active low
   input wire logic i_sdi, // Serial data pin, input side
   input wire logic [7:0] i_rdata, // Read data for o_addr
   output logic o_wr, // Write strobe, one cycle
   output logic [14:0] o_addr, // Register address
   output logic [7:0] o_wdata, // Write data
   output logic o_sdo, // Serial data pin, output side
   output logic o_sdo_oe // Serial data pin drive enable
);
   import acdp_pkg::*;

   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic sclk_d;
      acdp_spi_st_t st;
      logic [4:0] cnt;
      logic [15:0] sh;
      logic rnw;
      logic [14:0] addr;
      logic [7:0] rbuf;
      logic [7:0] wdata;
      logic wr;
      logic sdo;
      logic oe;
   } acdp_spi_reg_t;

   acdp_spi_reg_t st_ff;
   acdp_spi_reg_t nxt_st;
   logic rise;
   logic fall;

   // Pins are sampled, so the serial clock must stay well below a quarter of i_clock
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.s1 = {i_sclk, i_csb_n, i_sdi};
      nxt_st.s2 = st_ff.s1;
      nxt_st.sclk_d = st_ff.s2[2];
      nxt_st.wr = 1'b0;
      rise = st_ff.s2[2] && !st_ff.sclk_d;
      fall = !st_ff.s2[2] && st_ff.sclk_d;
      if (st_ff.s2[1])
      begin
         nxt_st.st = SPI_IDLE;
         nxt_st.cnt = 5'h00;
         nxt_st.oe = 1'b0;
      end
      else
      begin
         case (st_ff.st)
            SPI_IDLE, SPI_CMD:
            begin
               if (rise)
               begin
                  nxt_st.sh = {st_ff.sh[14:0], st_ff.s2[0]};
                  nxt_st.cnt = st_ff.cnt + 5'h01;
                  nxt_st.st = SPI_CMD;
                  if (nxt_st.cnt == `ACDP_SPI_CMD_BITS)
                  begin
                     nxt_st.st = SPI_DATA;
                     nxt_st.rnw = nxt_st.sh[15];
                     nxt_st.addr = nxt_st.sh[14:0];
                  end
               end
            end
            SPI_DATA:
            begin
               if (fall && st_ff.rnw)
               begin
                  nxt_st.oe = 1'b1;
                  if (st_ff.cnt == `ACDP_SPI_CMD_BITS)
                  begin
                     nxt_st.sdo = i_rdata[7];
                     nxt_st.rbuf = {i_rdata[6:0], 1'b0};
                  end
                  else
                  begin
                     nxt_st.sdo = st_ff.rbuf[7];
                     nxt_st.rbuf = {st_ff.rbuf[6:0], 1'b0};
                  end
               end
               if (rise)
               begin
                  nxt_st.sh = {st_ff.sh[14:0], st_ff.s2[0]};
                  nxt_st.cnt = st_ff.cnt + 5'h01;
                  if (nxt_st.cnt == `ACDP_SPI_FRAME_BITS)
                  begin
                     nxt_st.st = SPI_DONE;
                     nxt_st.wr = !st_ff.rnw;
                     nxt_st.wdata = nxt_st.sh[7:0];
                  end
               end
            end
            SPI_DONE: nxt_st.st = SPI_DONE;
            default: nxt_st.st = SPI_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign o_wr = st_ff.wr;
   assign o_addr = st_ff.addr;
   assign o_wdata = st_ff.wdata;
   assign o_sdo = st_ff.sdo;
   assign o_sdo_oe = st_ff.oe;
endmodule : acdp_spi_slave

// File: rtl/acdp_clock_ctrl.sv
// Sample clock divider, delay, power mode and diode export control with register port
//
// Functional notes
// - Sample clock divided by one, two or four as set in the divider register
// - A valid SYSREF loads the divider counter with a programmed state
// - Half input-period delay, enabled per channel in the half-period register
// - Half-period delay changes never disturb the serial output link
// - Three-bit delay mode; superfine active only for values 0x2 and 0x6
// - Eight-bit fine delay selects one of 192 steps
// - Eight-bit unsigned superfine delay, up to 128 steps of 0.25 ps
// - Fine and superfine values held separately per channel
// - Delay changes take effect at once, with no commit step
// - Enabling delay in the control register pulses a datapath reset
// - Rewriting fine or superfine values causes no reset of the link
// - Power pin active high, powers down by default rather than standby
// - Power-down drops the serial link; it runs again as soon as power-down ends
// - Power-down also selectable through the mode field of power register 0x003F
// - Standby keeps the link running and sends zero samples by default
// - Fill select bit set makes standby send /K/ characters instead
// - Diode register value 0x01 exports the 1x diode, 0x02 the 20x one
`include "acdp_regs.svh"
module acdp_clock_ctrl #(
   parameter int NUM_CH = 2, // Converter channels
   parameter int DPRST_CYC = `ACDP_DPRST_CYC // Datapath reset length in cycles
)
(
   input wire logic i_clock, // 200 MHz clock
   input wire logic i_rstn, // Async reset, active low
   input wire logic i_spi_sclk, // Serial clock pin
   input wire logic i_spi_csb_n, // Serial chip select, active low
   input wire logic i_spi_sdio, // Serial data pin, input side
   output logic o_spi_sdio, // Serial data pin, output side
   output logic o_spi_sdio_oe, // Serial data pin drive enable
   input wire logic i_sysref, // SYSREF pin
   input wire logic i_power_standby_pin, // Power control pin, active high
   output logic o_sample_en, // Divided sample clock enable
   output logic [NUM_CH-1:0] o_half_delay_en, // Half-period delay per channel
   output logic [NUM_CH-1:0] o_delay_en, // Fine delay path active per channel
   output logic [NUM_CH-1:0][7:0] o_fine_delay, // Fine delay step per channel
   output logic [NUM_CH-1:0][7:0] o_superfine_delay, // Superfine step per channel
   output logic o_datapath_rst, // Datapath reset, active high
   output logic o_power_down_mode, // Device powered down
   output logic o_standby, // Device in standby
   output logic o_link_enable, // Serial output link running
   output logic o_fill_k, // Standby fill with /K/ characters
   output logic o_fill_zero, // Standby fill with zero samples
   output logic o_temp_diode_1x, // 1x diode on reference pin
   output logic o_temp_diode_20x, // 20x diode on reference pin
   output logic o_common_mode_voltage_export, // Common-mode export on
   output logic o_ref_export, // Reference export on
   output logic o_export_conflict // More than one export enabled
);
   import acdp_pkg::*;

   localparam int RST_W = $clog2(DPRST_CYC + 1);
   localparam int CH_W = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;

   if (NUM_CH < 1 || NUM_CH > 8)
   begin : g_bad_ch
      $error("NUM_CH must be 1 to 8, one channel select bit each");
   end
   if (DPRST_CYC < 1)
   begin : g_bad_rst
      $error("DPRST_CYC must be at least one cycle");
   end

   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
      logic sysref_d;
      logic sync_pulse;
      logic [7:0] chan_sel;
      logic [7:0] pwr_a;
      logic [7:0] pwr_b;
      logic [7:0] clk_div;
      logic [7:0] fill_sel;
      logic [7:0] ref_src;
      logic [7:0] cm_exp;
      logic [7:0] diode;
      logic [NUM_CH-1:0][7:0] half;
      logic [NUM_CH-1:0][7:0] dly_ctl;
      logic [NUM_CH-1:0][7:0] sf;
      logic [NUM_CH-1:0][7:0] fine;
      logic [RST_W-1:0] rst_cnt;
      logic pwr_dn;
      logic stby;
      logic [NUM_CH-1:0] half_en;
      logic [NUM_CH-1:0] dly_en;
      logic [NUM_CH-1:0][7:0] fine_q;
      logic [NUM_CH-1:0][7:0] sf_q;
      logic dp_rst;
      logic link_en;
      logic fill_k;
      logic fill_zero;
      logic diode_1x;
      logic diode_20x;
      logic cm_en;
      logic ref_en;
      logic conflict;
   } acdp_top_reg_t;

   acdp_top_reg_t st_ff;
   acdp_top_reg_t nxt_st;

   logic spi_wr;
   logic [14:0] spi_addr;
   logic [7:0] spi_wdata;
   logic [7:0] rdata;
   logic [CH_W-1:0] rd_ch;
   logic [NUM_CH-1:0][7:0] half_n;
   logic [NUM_CH-1:0][7:0] ctl_n;
   logic [NUM_CH-1:0][7:0] sf_n;
   logic [NUM_CH-1:0][7:0] fine_n;
   logic [NUM_CH-1:0][7:0] fine_c;
   logic [NUM_CH-1:0][7:0] sf_c;
   logic [NUM_CH-1:0] ctl_on;
   logic [NUM_CH-1:0] sf_on;
   logic [NUM_CH-1:0] en_edge;
   acdp_pin_fn_t pin_fn;
   acdp_pwr_t reg_md;
   acdp_pwr_t pwr_md;
   logic pin_lvl;
   logic [1:0] exp_cnt;

   acdp_spi_slave u_spi (
      .i_clock (i_clock),
      .i_rstn (i_rstn),
      .i_sclk (i_spi_sclk),
      .i_csb_n (i_spi_csb_n),
      .i_sdi (i_spi_sdio),
      .i_rdata (rdata),
      .o_wr (spi_wr),
      .o_addr (spi_addr),
      .o_wdata (spi_wdata),
      .o_sdo (o_spi_sdio),
      .o_sdo_oe (o_spi_sdio_oe)
   );

   acdp_clk_div u_div (
      .i_clock (i_clock),
      .i_rstn (i_rstn),
      .i_ratio (acdp_div_t'(st_ff.clk_div[`ACDP_DIV_RATIO])),
      .i_sync (st_ff.sync_pulse),
      .i_phase (st_ff.clk_div[`ACDP_DIV_PHASE]),
      .o_div_en (o_sample_en)
   );

   // Per-channel register image and delay values
   for (genvar c = 0; c < NUM_CH; c++)
   begin : g_ch
      logic hit;
      assign hit = spi_wr && st_ff.chan_sel[c];
      assign half_n[c] = (hit && spi_addr == `ACDP_OFF_HALF_DLY) ? spi_wdata : st_ff.half[c];
      assign ctl_n[c] = (hit && spi_addr == `ACDP_OFF_DLY_CTL) ? spi_wdata : st_ff.dly_ctl[c];
      assign sf_n[c] = (hit && spi_addr == `ACDP_OFF_SF_DLY) ? spi_wdata : st_ff.sf[c];
      assign fine_n[c] = (hit && spi_addr == `ACDP_OFF_FINE_DLY) ? spi_wdata : st_ff.fine[c];
      assign ctl_on[c] = ctl_n[c][`ACDP_DLY_MODE] != `ACDP_DLY_OFF;
      assign en_edge[c] = ctl_on[c] && st_ff.dly_ctl[c][`ACDP_DLY_MODE] == `ACDP_DLY_OFF;
      assign sf_on[c] = ctl_n[c][`ACDP_DLY_MODE] == `ACDP_DLY_SF_A
         || ctl_n[c][`ACDP_DLY_MODE] == `ACDP_DLY_SF_B;
      // Out-of-range codes saturate at the last real step
      assign fine_c[c] = (fine_n[c] > `ACDP_FINE_MAX) ? `ACDP_FINE_MAX : fine_n[c];
      assign sf_c[c] = !sf_on[c] ? 8'h00
         : (sf_n[c] > `ACDP_SF_MAX) ? `ACDP_SF_MAX : sf_n[c];
   end

   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.s1 = {i_sysref, i_power_standby_pin};
      nxt_st.s2 = st_ff.s1;
      nxt_st.sysref_d = st_ff.s2[1];
      nxt_st.sync_pulse = st_ff.s2[1] && !st_ff.sysref_d
         && st_ff.clk_div[`ACDP_DIV_SYNC_EN];
      if (spi_wr)
      begin
         case (spi_addr)
            `ACDP_OFF_CHAN_SEL: nxt_st.chan_sel = spi_wdata;
            `ACDP_OFF_PWR_A: nxt_st.pwr_a = spi_wdata;
            `ACDP_OFF_PWR_B: nxt_st.pwr_b = spi_wdata;
            `ACDP_OFF_CLK_DIV: nxt_st.clk_div = spi_wdata;
            `ACDP_OFF_FILL_SEL: nxt_st.fill_sel = spi_wdata;
            `ACDP_OFF_REF_SRC: nxt_st.ref_src = spi_wdata;
            `ACDP_OFF_CM_EXP: nxt_st.cm_exp = spi_wdata;
            `ACDP_OFF_DIODE: nxt_st.diode = spi_wdata;
            default: nxt_st.chan_sel = st_ff.chan_sel;
         endcase
      end
      nxt_st.half = half_n;
      nxt_st.dly_ctl = ctl_n;
      nxt_st.sf = sf_n;
      nxt_st.fine = fine_n;

      // Delay outputs follow the write in the next cycle
      for (int c = 0; c < NUM_CH; c++)
      begin
         nxt_st.half_en[c] = half_n[c][`ACDP_HALF_EN];
      end
      nxt_st.dly_en = ctl_on;
      nxt_st.fine_q = fine_c;
      nxt_st.sf_q = sf_c;

      // Only a delay enable restarts the datapath; value writes keep the link aligned
      if (|en_edge)
         nxt_st.rst_cnt = RST_W'(DPRST_CYC);
      else if (st_ff.rst_cnt != '0)
         nxt_st.rst_cnt = st_ff.rst_cnt - RST_W'(1);
      nxt_st.dp_rst = nxt_st.rst_cnt != '0;

      pin_lvl = st_ff.s2[0];
      pin_fn = acdp_pin_fn_t'(nxt_st.pwr_b[`ACDP_PWR_PIN_FUNC]);
      reg_md = acdp_pwr_t'(nxt_st.pwr_a[`ACDP_PWR_REG_MODE]);
      if ((pin_lvl && pin_fn == PIN_POWER_DOWN_MODE) || reg_md == PWR_DOWN)
         pwr_md = PWR_DOWN;
      else if ((pin_lvl && pin_fn == PIN_STBY) || reg_md == PWR_STANDBY)
         pwr_md = PWR_STANDBY;
      else
         pwr_md = PWR_ON;
      nxt_st.pwr_dn = pwr_md == PWR_DOWN;
      nxt_st.stby = pwr_md == PWR_STANDBY;
      nxt_st.link_en = pwr_md != PWR_DOWN;
      nxt_st.fill_k = pwr_md == PWR_STANDBY && nxt_st.fill_sel[`ACDP_FILL_K_BIT];
      nxt_st.fill_zero = pwr_md == PWR_STANDBY && !nxt_st.fill_sel[`ACDP_FILL_K_BIT];

      nxt_st.diode_1x = nxt_st.diode == `ACDP_DIODE_1X;
      nxt_st.diode_20x = nxt_st.diode == `ACDP_DIODE_20X;
      nxt_st.cm_en = nxt_st.cm_exp[`ACDP_CM_EXP_BIT];
      nxt_st.ref_en = nxt_st.ref_src[`ACDP_REF_EXP_BIT];
      // Flag only: overlapping exports leave the pin voltage undefined
      exp_cnt = {1'b0, nxt_st.diode != 8'h00} + {1'b0, nxt_st.cm_en}
         + {1'b0, nxt_st.ref_en};
      nxt_st.conflict = exp_cnt > 2'h1;
   end

   // Per-channel readback shows the lowest selected channel
   always_comb
   begin
      rd_ch = '0;
      for (int c = NUM_CH - 1; c >= 0; c--)
      begin
         if (st_ff.chan_sel[c])
            rd_ch = CH_W'(c);
      end
      case (spi_addr)
         `ACDP_OFF_CHAN_SEL: rdata = st_ff.chan_sel;
         `ACDP_OFF_PWR_A: rdata = st_ff.pwr_a;
         `ACDP_OFF_PWR_B: rdata = st_ff.pwr_b;
         `ACDP_OFF_CLK_DIV: rdata = st_ff.clk_div;
         `ACDP_OFF_HALF_DLY: rdata = st_ff.half[rd_ch];
         `ACDP_OFF_DLY_CTL: rdata = st_ff.dly_ctl[rd_ch];
         `ACDP_OFF_SF_DLY: rdata = st_ff.sf[rd_ch];
         `ACDP_OFF_FINE_DLY: rdata = st_ff.fine[rd_ch];
         `ACDP_OFF_FILL_SEL: rdata = st_ff.fill_sel;
         `ACDP_OFF_REF_SRC: rdata = st_ff.ref_src;
         `ACDP_OFF_CM_EXP: rdata = st_ff.cm_exp;
         `ACDP_OFF_DIODE: rdata = st_ff.diode;
         default: rdata = 8'h00;
      endcase
   end

   always_ff @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         st_ff <= '0;
         st_ff.chan_sel <= `ACDP_RST_CHAN_SEL;
         st_ff.link_en <= 1'b1;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign o_half_delay_en = st_ff.half_en;
   assign o_delay_en = st_ff.dly_en;
   assign o_fine_delay = st_ff.fine_q;
   assign o_superfine_delay = st_ff.sf_q;
   assign o_datapath_rst = st_ff.dp_rst;
   assign o_power_down_mode = st_ff.pwr_dn;
   assign o_standby = st_ff.stby;
   assign o_link_enable = st_ff.link_en;
   assign o_fill_k = st_ff.fill_k;
   assign o_fill_zero = st_ff.fill_zero;
   assign o_temp_diode_1x = st_ff.diode_1x;
   assign o_temp_diode_20x = st_ff.diode_20x;
   assign o_common_mode_voltage_export = st_ff.cm_en;
   assign o_ref_export = st_ff.ref_en;
   assign o_export_conflict = st_ff.conflict;

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rstn);

   sequence s_dly_enable_wr;
      spi_wr && spi_addr == `ACDP_OFF_DLY_CTL && st_ff.chan_sel[0]
         && spi_wdata[`ACDP_DLY_MODE] != `ACDP_DLY_OFF
         && st_ff.dly_ctl[0][`ACDP_DLY_MODE] == `ACDP_DLY_OFF;
   endsequence
   sequence s_pin_held;
      (i_power_standby_pin && st_ff.pwr_b[`ACDP_PWR_PIN_FUNC] == 2'h0)[*3];
   endsequence

   AST_DPRST_PULSE: assert property (s_dly_enable_wr
      |=> o_datapath_rst && st_ff.rst_cnt == RST_W'(DPRST_CYC))
      else $error("datapath reset not started after delay enable");
   AST_DPRST_HOLD: assert property (o_datapath_rst && st_ff.rst_cnt != RST_W'(1)
      |=> o_datapath_rst)
      else $error("datapath reset dropped early");
   AST_DPRST_END: assert property (o_datapath_rst && st_ff.rst_cnt == RST_W'(1)
      && !(|en_edge) |=> !o_datapath_rst)
      else $error("datapath reset held too long");
   AST_PD_REG: assert property (acdp_pwr_t'(st_ff.pwr_a[`ACDP_PWR_REG_MODE]) == PWR_DOWN
      |-> o_power_down_mode && !o_link_enable)
      else $error("register power-down not applied");
   AST_VALUE_NO_RST: assert property (spi_wr && !o_datapath_rst
      && (spi_addr == `ACDP_OFF_FINE_DLY || spi_addr == `ACDP_OFF_SF_DLY)
      |=> !o_datapath_rst)
      else $error("delay value write reset the datapath");
   AST_FINE_NOW: assert property (spi_wr && spi_addr == `ACDP_OFF_FINE_DLY
      && st_ff.chan_sel[0] && spi_wdata <= `ACDP_FINE_MAX
      |=> o_fine_delay[0] == $past(spi_wdata))
      else $error("fine delay not applied in the next cycle");
   AST_FINE_RANGE: assert property (o_fine_delay[0] <= `ACDP_FINE_MAX)
      else $error("fine delay beyond last step");
   AST_CHSEL_MASK: assert property (spi_wr && spi_addr == `ACDP_OFF_FINE_DLY
      && !st_ff.chan_sel[NUM_CH-1] |=> $stable(o_fine_delay[NUM_CH-1]))
      else $error("unselected channel delay changed");
   AST_SF_GATE: assert property (st_ff.dly_ctl[0][`ACDP_DLY_MODE] != `ACDP_DLY_SF_A
      && st_ff.dly_ctl[0][`ACDP_DLY_MODE] != `ACDP_DLY_SF_B |-> o_superfine_delay[0] == 8'h00)
      else $error("superfine delay active in fine-only mode");
   AST_PIN_POWER_DOWN_MODE: assert property (s_pin_held |=> o_power_down_mode)
      else $error("power pin did not power down");
   AST_PD_LINK: assert property (o_power_down_mode |-> !o_link_enable && !o_standby)
      else $error("link running in power-down");
   AST_STBY_FILL: assert property (o_standby |-> o_link_enable
      && (o_fill_k == st_ff.fill_sel[`ACDP_FILL_K_BIT]) && (o_fill_zero != o_fill_k))
      else $error("standby fill wrong");
   AST_DIODE_20X: assert property (spi_wr && spi_addr == `ACDP_OFF_DIODE
      && spi_wdata == `ACDP_DIODE_20X |=> o_temp_diode_20x && !o_temp_diode_1x)
      else $error("20x diode not exported");
endmodule : acdp_clock_ctrl

// File: testbench/acdp_spi_host.sv
// Host model driving the serial register port
module acdp_spi_host
(
   input wire logic i_clock, // 200 MHz clock
   input wire logic i_sdo, // Resolved serial data line
   output logic o_sclk, // Serial clock, idle low
   output logic o_csb_n, // Chip select, active low
   output logic o_sdio // Serial data towards device
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      o_sclk = 1'b0;
      o_csb_n = 1'b1;
      o_sdio = 1'b0;
   end
   // Six-cycle phases leave margin over the device's pin synchronisers
   task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] d,
      output logic [7:0] q);
      logic [23:0] frame;
      frame = {rd, a, d};
      @(negedge i_clock);
      o_csb_n = 1'b0;
      for (int i = 23; i >= 0; i--)
      begin
         // Read data phase: toggle so an undriven line never matches
         o_sdio = (rd && i < 8) ? ~o_sdio : frame[i];
         repeat (6) @(negedge i_clock);
         q[i%8] = i_sdo;
         o_sclk = 1'b1;
         repeat (6) @(negedge i_clock);
         o_sclk = 1'b0;
      end
      o_csb_n = 1'b1;
      o_sdio = ~o_sdio;
      repeat (8) @(negedge i_clock);
   endtask : xfer
endmodule : acdp_spi_host

// File: testbench/test_acdp_clock_ctrl.sv
// Self-checking bench for the clock control block
module test_acdp_clock_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [14:0] a; logic [7:0] d; logic [7:0] r;} acdp_row_t;
   localparam int DPR = 4;
   logic clk = 1'b0, rstn = 1'b0, sysref = 1'b0, pin = 1'b0;
   logic sclk, csb_n, hsd, se, dpr, pd, sb, le, fk, fz, d1, d20, cm, rf, cf, sdo, oe;
   logic [1:0] hd, de;
   logic [1:0][7:0] fd, sf;
   logic [7:0] rdat;
   int fail_count = 0, checks_done = 0, dp_cnt = 0, n, d0;
   wire sdw = oe ? sdo : hsd;
   acdp_row_t rows[7] = '{'{15'h0109, 8'h01, 8'h01}, '{15'h0110, 8'h06, 8'h06},
      '{15'h0111, 8'h90, 8'h90}, '{15'h0112, 8'hc5, 8'hc5}, '{15'h0571, 8'h80, 8'h80},
      '{15'h0108, 8'h01, 8'h01}, '{15'h7000, 8'h5a, 8'h00}};
   always #2.5 clk = ~clk;
   always @(posedge clk) if (dpr === 1'b1) dp_cnt <= dp_cnt + 1;
   acdp_spi_host u_acdp_spi_host (.i_clock(clk), .i_sdo(sdw), .o_sclk(sclk),
      .o_csb_n(csb_n), .o_sdio(hsd));
   acdp_clock_ctrl #(.NUM_CH(2), .DPRST_CYC(DPR)) u_acdp_clock_ctrl (.i_clock(clk),
      .i_rstn(rstn), .i_spi_sclk(sclk), .i_spi_csb_n(csb_n), .i_spi_sdio(sdw),
      .o_spi_sdio(sdo), .o_spi_sdio_oe(oe), .i_sysref(sysref), .i_power_standby_pin(pin),
      .o_sample_en(se), .o_half_delay_en(hd), .o_delay_en(de), .o_fine_delay(fd),
      .o_superfine_delay(sf), .o_datapath_rst(dpr), .o_power_down_mode(pd),
      .o_standby(sb), .o_link_enable(le), .o_fill_k(fk), .o_fill_zero(fz),
      .o_temp_diode_1x(d1), .o_temp_diode_20x(d20), .o_common_mode_voltage_export(cm),
      .o_ref_export(rf), .o_export_conflict(cf));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      u_acdp_spi_host.xfer(1'b0, a, d, rdat);
   endtask : wr
   task automatic rd(input logic [14:0] a, input logic [7:0] e);
      u_acdp_spi_host.xfer(1'b1, a, 8'h00, rdat);
      chk(rdat, e);
   endtask : rd
   // Edge-to-edge spacing is fixed so a missed resync shows as a shifted pulse
   task automatic sync_gap(input int pre, output int d);
      repeat (pre) @(negedge clk);
      sysref = 1'b1;
      for (d = 1; d < 20 && !(se === 1'b1 && d > 4); d++) @(negedge clk);
      sysref = 1'b0;
      repeat (20 - d) @(negedge clk);
   endtask : sync_gap
   task automatic close_out;
      $display("Checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : close_out
   initial
   begin
      repeat (5) @(negedge clk);
      rstn = 1'b1;
      @(negedge clk);
      chk({le, pd, sb, dpr}, 16'h0008);
      rd(15'h0008, 8'h03);
      foreach (rows[i])
      begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].r);
      end
      chk({hd, de}, 16'h000f);
      chk(fd, 16'hbfbf);
      chk(sf, 16'h8080);
      chk({le, 15'(dp_cnt)}, 16'(32768 + DPR));
      $display("Test registers done");
      wr(15'h0008, 8'h01);
      wr(15'h0112, 8'h20);
      wr(15'h0008, 8'h02);
      wr(15'h0110, 8'h01);
      chk(fd, 16'hbf20);
      chk(sf, 16'h0080);
      wr(15'h0110, 8'h02);
      chk(sf, 16'h8080);
      chk(16'(dp_cnt), 16'(DPR));
      rd(15'h0112, 8'hc5);
      $display("Test channels done");
      for (int k = 0; k < 3; k++)
      begin
         wr(15'h0108, 8'(k));
         n = 0;
         repeat (40) @(negedge clk) if (se === 1'b1) n++;
         chk(16'(n), 16'(40 >> k));
      end
      wr(15'h0108, 8'h82);
      sync_gap(0, d0);
      sync_gap(2, n);
      chk(16'(n), 16'(d0));
      chk(16'(d0), 16'h0005);
      wr(15'h0108, 8'h92);
      sync_gap(0, n);
      chk(16'(n), 16'h0008);
      $display("Test divider done");
      pin = 1'b1;
      repeat (8) @(negedge clk);
      chk({pd, sb, le}, 16'h0004);
      pin = 1'b0;
      wr(15'h0040, 8'h40);
      pin = 1'b1;
      repeat (8) @(negedge clk);
      chk({pd, sb, le, fk, fz}, 16'h000e);
      wr(15'h0571, 8'h00);
      chk({pd, sb, le, fk, fz}, 16'h000d);
      pin = 1'b0;
      wr(15'h003f, 8'h02);
      chk({pd, le}, 16'h0002);
      wr(15'h003f, 8'h01);
      chk({pd, sb, le}, 16'h0003);
      wr(15'h003f, 8'h00);
      wr(15'h0040, 8'h80);
      pin = 1'b1;
      repeat (8) @(negedge clk);
      chk({pd, sb, le}, 16'h0001);
      pin = 1'b0;
      $display("Test power done");
      wr(15'h0008, 8'h03);
      wr(15'h18e3, 8'h00);
      wr(15'h18a6, 8'h00);
      for (int k = 1; k < 3; k++)
      begin
         wr(15'h18e6, 8'(k));
         chk({d1, d20, cm, rf, cf}, 16'(k == 1 ? 16 : 8));
      end
      wr(15'h18e3, 8'h40);
      chk({d20, cm, rf, cf}, 16'h000d);
      wr(15'h18a6, 8'h01);
      chk({cm, rf, cf}, 16'h0007);
      $display("Test diode done");
      rstn = 1'b0;
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      @(negedge clk);
      chk({le, pd, sb, dpr, cf, d20, se}, 16'h0041);
      rd(15'h18e6, 8'h00);
      rd(15'h0008, 8'h03);
      $display("Test reset done");
      close_out;
   end
   initial
   begin
      #200000;
      fail_count++;
      $display("Error at %0t: timeout", $time);
      close_out;
   end
endmodule : test_acdp_clock_ctrl
